// ---- design/liwl_addr_gen.sv ----
// address generator for word loads: effective address, writeback, checks
`timescale 1ns/1ps
`default_nettype none
module liwl_addr_gen
   import liwl_pkg::*;
(
   input wire liwl_pkg::liwl_op_t op,
   input wire logic [31:0] base,
   input wire logic [31:0] index_val,
   input wire logic [16:0] offset,
   input wire logic same_ptr,
   input wire logic dest_is_base,
   output logic [31:0] eff_addr,
   output logic [31:0] new_base,
   output logic base_write,
   output logic misaligned,
   output logic illegal
);
   always_comb begin
      eff_addr = base;
      new_base = base;
      base_write = 1'b0;
      case (op)
         LIWL_OP_LD_INC: begin
            new_base = base + 32'(ADDR_INC);
            base_write = 1'b1;
         end
         LIWL_OP_LD_DEC: begin
            new_base = base - 32'(ADDR_INC);
            base_write = 1'b1;
         end
         LIWL_OP_LD_SHORT: eff_addr = base + {26'h0, offset[5:0]};
         LIWL_OP_LD_LONG_ADD: eff_addr = base + {15'h0, offset};
         LIWL_OP_LD_LONG_SUB: eff_addr = base - {15'h0, offset};
         LIWL_OP_LD_FRAME: eff_addr = base - {24'h0, offset[7:0]};
         LIWL_OP_LD_IDX_POST: begin
            new_base = base + index_val;
            base_write = !same_ptr;
         end
         default: ;
      endcase
   end
   assign misaligned = |(eff_addr[1:0] & ALIGN_MASK);
   assign illegal = dest_is_base &&
      (op == LIWL_OP_LD_INC || op == LIWL_OP_LD_DEC);
endmodule // liwl_addr_gen
`default_nettype wire

// ---- design/liwl_unit.sv ----
// immediate-load and word-load execution unit with its register file
// Operation
// - half load writes sixteen bits into one half, other half kept
// - zero form fills upper bits with zeros, sign form with sign
// - short signed constant is seven bits, range -64 to 63
// - long signed constant spans -32768 to 32767 before extension
// - half and zero-extended loads take unsigned 0 to 65535
// - accumulators load only zero: clear one or both
// - accumulator clear may issue in parallel with others
// - any data, pointer, index, modifier, base, length reg is a target; code limits short constant and word loads to data and pointer regs
// - pointer load fetches one word and writes it whole
// - word load address must be multiple of four else exception
// - post inc or dec fetches old pointer then moves it four bytes
// - short offset adds unsigned word multiple 0 to 60
// - long offset adds or subtracts up to 131068 bytes
// - frame load subtracts 4 to 128 bytes from frame pointer; code takes an 8-bit offset, 0 to 255
// - destination equal to auto-modified pointer is undefined instr; code flags it for post inc and dec only, not indexed post-modify
// - long offset forms are 32-bit encodings, others 16-bit
// - 32-bit load encodings issue alone, 16-bit may pair
// - data load may use pointer or index, index post-modify by modifier
// - indexed post-increment loads first source then adds second
// - same register as both operands: no increment; code still increments when that register is an index reg
`timescale 1ns/1ps
`default_nettype none
module liwl_unit
   import liwl_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic issue,
   input wire liwl_pkg::liwl_op_t op,
   input wire logic paired,
   input wire logic [5:0] dest,
   input wire logic [5:0] src1,
   input wire logic [5:0] src2,
   input wire logic [16:0] imm,
   input wire logic mem_ready,
   input wire logic [31:0] mem_rdata,
   input wire logic [5:0] read_sel,
   output logic busy,
   output logic mem_req,
   output logic [31:0] mem_addr,
   output logic [31:0] read_data,
   output logic [39:0] acc0,
   output logic [39:0] acc1,
   output logic exc_misaligned,
   output logic exc_undefined,
   output logic long_encoding,
   output logic done
);
   import liwl_pkg::*;
   typedef enum logic [0:0] {LIWL_IDLE, LIWL_WAIT} liwl_state_t;
   liwl_state_t state, next_state;
   logic [31:0] regs [NUM_REGS];
   logic [31:0] next_regs [NUM_REGS];
   logic [39:0] next_acc0, next_acc1;
   logic [5:0] pend_dest, next_pend_dest;
   logic [31:0] next_mem_addr, next_read_data;
   logic next_mem_req, next_busy, next_done;
   logic next_exc_mis, next_exc_undef, next_long;
   logic [31:0] eff_addr, new_base;
   logic base_write, misaligned, illegal;
   logic is_load, is_long, full_dest_ok, mod_form;
   logic [31:0] idx_val, base_val;
   logic [16:0] ofs;
   assign is_load = op >= LIWL_OP_LD_IND;
   assign is_long = op == LIWL_OP_LD_LONG_ADD ||
      op == LIWL_OP_LD_LONG_SUB;
   assign mod_form = src1 >= IDX_INDEX0 && src1 < IDX_MOD0;
   assign full_dest_ok = dest <= IDX_LAST;
   // index post-modify adds a modifier register; pointer form adds a pointer
   assign idx_val = regs[src2[$clog2(NUM_REGS)-1:0]];
   assign ofs = (op == LIWL_OP_LD_FRAME) ? {9'h0, imm[7:0]} : imm;
   // frame form always works from the frame pointer
   assign base_val = (op == LIWL_OP_LD_FRAME) ? regs[IDX_FRAME] :
      regs[src1];
   liwl_addr_gen u_addr (
      .op(op),
      .base(base_val),
      .index_val(idx_val),
      .offset(ofs),
      .same_ptr(src1 == src2 && !mod_form),
      .dest_is_base(dest == src1),
      .eff_addr(eff_addr),
      .new_base(new_base),
      .base_write(base_write),
      .misaligned(misaligned),
      .illegal(illegal)
   );
   always_comb begin
      next_state = state;
      next_regs = regs;
      next_acc0 = acc0;
      next_acc1 = acc1;
      next_pend_dest = pend_dest;
      next_mem_addr = mem_addr;
      next_mem_req = mem_req;
      next_busy = busy;
      next_done = 1'b0;
      next_exc_mis = 1'b0;
      next_exc_undef = 1'b0;
      next_long = long_encoding;
      next_read_data = regs[read_sel < IDX_ACC0 ? read_sel : IDX_DATA0];
      case (state)
         LIWL_IDLE: begin
            if (issue) begin
               next_long = is_load && is_long;
               if (is_load && is_long && paired) begin
                  next_exc_undef = 1'b1;
               end else if (paired && !is_load && op != LIWL_OP_NOP &&
                  op != LIWL_OP_ACC0_CLR && op != LIWL_OP_ACC1_CLR &&
                  op != LIWL_OP_ACC_BOTH_CLR) begin
                  next_exc_undef = 1'b1;
               end else begin
                  case (op)
                     LIWL_OP_IMM_LO: if (full_dest_ok) begin
                        next_regs[dest][15:0] = imm[15:0];
                        next_done = 1'b1;
                     end else next_exc_undef = 1'b1;
                     LIWL_OP_IMM_HI: if (full_dest_ok) begin
                        next_regs[dest][31:16] = imm[15:0];
                        next_done = 1'b1;
                     end else next_exc_undef = 1'b1;
                     LIWL_OP_IMM_ZX: if (full_dest_ok) begin
                        next_regs[dest] = {16'h0, imm[15:0]};
                        next_done = 1'b1;
                     end else next_exc_undef = 1'b1;
                     LIWL_OP_SHORT_SIGNED_CONSTANT_SX: if (dest < IDX_INDEX0) begin
                        next_regs[dest] = 32'(signed'(imm[6:0]));
                        next_done = 1'b1;
                     end else next_exc_undef = 1'b1;
                     LIWL_OP_LONG_SIGNED_CONSTANT_SX: if (full_dest_ok) begin
                        next_regs[dest] = 32'(signed'(imm[15:0]));
                        next_done = 1'b1;
                     end else next_exc_undef = 1'b1;
                     LIWL_OP_ACC0_CLR: begin
                        next_acc0 = '0;
                        next_done = 1'b1;
                     end
                     LIWL_OP_ACC1_CLR: begin
                        next_acc1 = '0;
                        next_done = 1'b1;
                     end
                     LIWL_OP_ACC_BOTH_CLR: begin
                        next_acc0 = '0;
                        next_acc1 = '0;
                        next_done = 1'b1;
                     end
                     LIWL_OP_NOP: next_done = 1'b1;
                     default: begin
                        if (illegal || dest >= IDX_INDEX0) begin
                           next_exc_undef = 1'b1;
                        end else if (misaligned) begin
                           next_exc_mis = 1'b1;
                        end else begin
                           next_mem_addr = eff_addr;
                           next_mem_req = 1'b1;
                           next_busy = 1'b1;
                           next_pend_dest = dest;
                           if (base_write) begin
                              next_regs[src1] = new_base;
                           end
                           next_state = LIWL_WAIT;
                        end
                     end
                  endcase
               end
            end
         end
         LIWL_WAIT: begin
            if (mem_ready) begin
               next_regs[pend_dest] = mem_rdata;
               next_mem_req = 1'b0;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_state = LIWL_IDLE;
            end
         end
         default: next_state = LIWL_IDLE;
      endcase
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= LIWL_IDLE;
         for (int i = 0; i < NUM_REGS; i++) regs[i] <= '0;
         acc0 <= '0;
         acc1 <= '0;
         pend_dest <= '0;
         mem_addr <= '0;
         mem_req <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         exc_misaligned <= 1'b0;
         exc_undefined <= 1'b0;
         long_encoding <= 1'b0;
         read_data <= '0;
      end else begin
         state <= next_state;
         regs <= next_regs;
         acc0 <= next_acc0;
         acc1 <= next_acc1;
         pend_dest <= next_pend_dest;
         mem_addr <= next_mem_addr;
         mem_req <= next_mem_req;
         busy <= next_busy;
         done <= next_done;
         exc_misaligned <= next_exc_mis;
         exc_undefined <= next_exc_undef;
         long_encoding <= next_long;
         read_data <= next_read_data;
      end
   end
   property p_post_inc;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_LD_INC &&
       !illegal && !misaligned && dest < IDX_INDEX0)
      |=> (mem_addr == $past(regs[src1]) &&
           regs[$past(src1)] == $past(regs[src1]) + 32'h4);
   endproperty
   a_post_inc: assert property (p_post_inc)
      else $error("post increment wrong");
   property p_misaligned;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && is_load && !paired && !illegal &&
       dest < IDX_INDEX0 && misaligned) |=> exc_misaligned && !mem_req;
   endproperty
   a_misaligned: assert property (p_misaligned)
      else $error("misaligned not flagged");
   property p_undef;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && illegal && !paired)
      |=> exc_undefined && regs[$past(src1)] == $past(regs[src1]);
   endproperty
   a_undef: assert property (p_undef)
      else $error("undefined instruction not raised");
   property p_long_alone;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && is_long && paired)
      |=> !mem_req && exc_undefined;
   endproperty
   a_long_alone: assert property (p_long_alone)
      else $error("paired long load issued");
   property p_acc_clear;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_ACC_BOTH_CLR)
      |=> acc0 == '0 && acc1 == '0 && done;
   endproperty
   a_acc_clear: assert property (p_acc_clear)
      else $error("accumulators not cleared");
   property p_half_keep;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_IMM_LO && !paired &&
       full_dest_ok) |=> regs[$past(dest)][31:16] ==
         $past(regs[dest][31:16]) && regs[$past(dest)][15:0] ==
         $past(imm[15:0]);
   endproperty
   a_half_keep: assert property (p_half_keep)
      else $error("half load disturbed other half");
   property p_fill;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_LONG_SIGNED_CONSTANT_SX && !paired &&
       full_dest_ok) |=> regs[$past(dest)][31:16] == {16{$past(imm[15])}};
   endproperty
   a_fill: assert property (p_fill)
      else $error("sign fill wrong");
   property p_load_data;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_WAIT && mem_ready)
      |=> regs[$past(pend_dest)] == $past(mem_rdata) && done && !busy;
   endproperty
   a_load_data: assert property (p_load_data)
      else $error("loaded word not written");
   property p_zero_fill;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_IMM_ZX && !paired &&
       full_dest_ok) |=> regs[$past(dest)] == {16'h0, $past(imm[15:0])};
   endproperty
   a_zero_fill: assert property (p_zero_fill)
      else $error("zero fill wrong");
   property p_short_sign;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_SHORT_SIGNED_CONSTANT_SX && !paired &&
       dest < IDX_INDEX0) |=> regs[$past(dest)] ==
         {{25{$past(imm[6])}}, $past(imm[6:0])};
   endproperty
   a_short_sign: assert property (p_short_sign)
      else $error("short constant extension wrong");
   property p_same_ptr;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_LD_IDX_POST &&
       src1 == src2 && !mod_form && !misaligned && dest < IDX_INDEX0)
      |=> regs[$past(src1)] == $past(regs[src1]) && mem_req;
   endproperty
   a_same_ptr: assert property (p_same_ptr)
      else $error("shared operand was incremented");
   property p_idx_post;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && op == LIWL_OP_LD_IDX_POST &&
       (src1 != src2 || mod_form) && !misaligned && dest < IDX_INDEX0)
      |=> mem_addr == $past(regs[src1]) &&
          regs[$past(src1)] == $past(regs[src1]) + $past(regs[src2]);
   endproperty
   a_idx_post: assert property (p_idx_post)
      else $error("indexed post-modify wrong");
   property p_fault_keep;
      @(posedge clock) disable iff (!reset_n)
      (state == LIWL_IDLE && issue && is_load && (misaligned || illegal))
      |=> !busy && regs[$past(dest)] == $past(regs[dest]) &&
          regs[$past(src1)] == $past(regs[src1]);
   endproperty
   a_fault_keep: assert property (p_fault_keep)
      else $error("faulting load changed a register");
endmodule // liwl_unit
`default_nettype wire

// ---- include/liwl_pkg.sv ----
// package: constants and types for the immediate and word load unit
package liwl_pkg;
   localparam int WORD_W = 32;
   localparam int HALF_W = 16;
   localparam int ACC_W = 40;
   localparam int REG_IDX_W = 6;
   localparam int NUM_REGS = 40;
   localparam int ADDR_INC = 4;
   localparam logic [1:0] ALIGN_MASK = 2'h3;
   localparam int SHORT_IMM_W = 7;
   localparam int SHORT_OFS_W = 6;
   localparam int FRAME_OFS_W = 7;
   localparam int LONG_OFS_W = 17;
   // register file index map
   localparam logic [5:0] IDX_DATA0 = 6'h00;
   localparam logic [5:0] IDX_PTR0 = 6'h08;
   localparam logic [5:0] IDX_STACK = 6'h0E;
   localparam logic [5:0] IDX_FRAME = 6'h0F;
   localparam logic [5:0] IDX_INDEX0 = 6'h10;
   localparam logic [5:0] IDX_MOD0 = 6'h14;
   localparam logic [5:0] IDX_BASE0 = 6'h18;
   localparam logic [5:0] IDX_LEN0 = 6'h1C;
   localparam logic [5:0] IDX_LAST = 6'h1F;
   localparam logic [5:0] IDX_ACC0 = 6'h20;
   localparam logic [5:0] IDX_ACC1 = 6'h21;
   typedef enum logic [4:0] {
      LIWL_OP_NOP,
      LIWL_OP_IMM_LO,
      LIWL_OP_IMM_HI,
      LIWL_OP_IMM_ZX,
      LIWL_OP_SHORT_SIGNED_CONSTANT_SX,
      LIWL_OP_LONG_SIGNED_CONSTANT_SX,
      LIWL_OP_ACC0_CLR,
      LIWL_OP_ACC1_CLR,
      LIWL_OP_ACC_BOTH_CLR,
      LIWL_OP_LD_IND,
      LIWL_OP_LD_INC,
      LIWL_OP_LD_DEC,
      LIWL_OP_LD_SHORT,
      LIWL_OP_LD_LONG_ADD,
      LIWL_OP_LD_LONG_SUB,
      LIWL_OP_LD_FRAME,
      LIWL_OP_LD_IDX_POST
   } liwl_op_t;
endpackage

// ---- verification/liwl_mem_model.sv ----
// data memory model: word reads answered after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module liwl_mem_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] delay,
   output logic mem_ready,
   output logic [31:0] mem_rdata
);
   logic [1:0] cnt;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mem_ready <= 1'b0;
         mem_rdata <= 32'h0;
         cnt <= 2'h0;
      end else if (mem_req && !mem_ready && cnt == delay) begin
         mem_ready <= 1'b1;
         mem_rdata <= mem_addr ^ 32'h5A5AA5A5;
      end else begin
         // data churns outside the answer cycle
         mem_ready <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt <= (mem_req && !mem_ready) ? cnt + 2'h1 : 2'h0;
      end
   end
endmodule // liwl_mem_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the immediate and word load unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   import liwl_pkg::*;
   logic clock, reset_n, issue, paired, mem_ready, busy, mem_req, done;
   logic exc_misaligned, exc_undefined, long_encoding;
   liwl_op_t op;
   logic [5:0] dest, src1, src2, read_sel;
   logic [16:0] imm;
   logic [31:0] mem_rdata, mem_addr, read_data, seed;
   logic [39:0] acc0, acc1;
   logic [1:0] delay, got;
   logic [31:0] regs [0:31];
   logic [1:0] notes [$];
   int num_errors, num_checks, cycles;
   liwl_unit u_liwl_unit (.clock(clock), .reset_n(reset_n), .issue(issue),
      .op(op), .paired(paired), .dest(dest), .src1(src1), .src2(src2),
      .imm(imm), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
      .read_sel(read_sel), .busy(busy), .mem_req(mem_req),
      .mem_addr(mem_addr), .read_data(read_data), .acc0(acc0),
      .acc1(acc1), .exc_misaligned(exc_misaligned),
      .exc_undefined(exc_undefined), .long_encoding(long_encoding),
      .done(done));
   liwl_mem_model u_liwl_mem_model (.clock(clock), .reset_n(reset_n),
      .mem_req(mem_req), .mem_addr(mem_addr), .delay(delay),
      .mem_ready(mem_ready), .mem_rdata(mem_rdata));
   always #25 clock = ~clock;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // result monitor: each done or exception takes the oldest note
   always @(posedge clock) begin
      if (reset_n && (done | exc_misaligned | exc_undefined) === 1'b1) begin
         got = (notes.size() > 0) ? notes.pop_front() : 2'bxx;
         check("exceptions", {38'h0, exc_misaligned, exc_undefined},
            {38'h0, got});
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic run(liwl_op_t o, logic p, logic [5:0] d, logic [5:0] s,
      logic [5:0] t, logic [16:0] im);
      logic [31:0] a;
      logic ld, lg, mis, und;
      ld = o >= LIWL_OP_LD_IND;
      lg = o inside {LIWL_OP_LD_LONG_ADD, LIWL_OP_LD_LONG_SUB};
      case (o)
         LIWL_OP_LD_SHORT, LIWL_OP_LD_LONG_ADD: a = regs[s] + 32'(im);
         LIWL_OP_LD_LONG_SUB: a = regs[s] - 32'(im);
         LIWL_OP_LD_FRAME: a = regs[IDX_FRAME] - 32'(im[7:0]);
         default: a = regs[s];
      endcase
      und = (p && (lg || o inside {[LIWL_OP_IMM_LO:LIWL_OP_LONG_SIGNED_CONSTANT_SX]}))
         || (o inside {LIWL_OP_LD_INC, LIWL_OP_LD_DEC} && d == s)
         || ((ld || o == LIWL_OP_SHORT_SIGNED_CONSTANT_SX) && d >= IDX_INDEX0);
      mis = ld && !und && (a[1:0] & ALIGN_MASK) != 2'h0;
      notes.push_back({mis, und});
      while (busy !== 1'b0) begin
         @(posedge clock);
         #1;
      end
      delay = 2'(rnd());
      issue = 1'b1;
      op = o;
      paired = p;
      dest = d;
      src1 = s;
      src2 = t;
      imm = im;
      @(posedge clock);
      #1;
      issue = 1'b0;
      op = liwl_op_t'(5'(rnd() % 17));
      check("long encoding", {39'h0, long_encoding}, {39'h0, lg});
      if (ld && !mis && !und)
         check("address", {8'h0, mem_addr}, {8'h0, a});
      if (!mis && !und) begin
         case (o)
            LIWL_OP_IMM_LO: regs[d][15:0] = im[15:0];
            LIWL_OP_IMM_HI: regs[d][31:16] = im[15:0];
            LIWL_OP_IMM_ZX: regs[d] = {16'h0, im[15:0]};
            LIWL_OP_SHORT_SIGNED_CONSTANT_SX: regs[d] = {{25{im[6]}}, im[6:0]};
            LIWL_OP_LONG_SIGNED_CONSTANT_SX: regs[d] = {{16{im[15]}}, im[15:0]};
            LIWL_OP_LD_INC: regs[s] = regs[s] + 32'h4;
            LIWL_OP_LD_DEC: regs[s] = regs[s] - 32'h4;
            LIWL_OP_LD_IDX_POST:
               if (s != t) regs[s] = regs[s] + regs[t];
            default: ;
         endcase
         if (ld) regs[d] = a ^ 32'h5A5AA5A5;
      end
      repeat (40) begin
         @(posedge clock);
         if ((done | exc_misaligned | exc_undefined) === 1'b1) break;
      end
      #1;
   endtask
   task automatic chk_all(string name);
      for (int i = 0; i < 32; i++) begin
         read_sel = 6'(i);
         @(posedge clock);
         @(posedge clock);
         #1;
         check("register", {8'h0, read_data}, {8'h0, regs[i]});
      end
      check("acc0", acc0, 40'h0);
      check("acc1", acc1, 40'h0);
      $display("test %s finished", name);
   endtask
   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      {issue, paired, dest, src1, src2, imm, read_sel, delay} = '0;
      op = LIWL_OP_NOP;
      seed = 32'h3;
      for (int i = 0; i < 32; i++) regs[i] = 32'h0;
      repeat (3) @(posedge clock);
      #1;
      reset_n = 1'b1;
      for (int i = 0; i < 32; i++) begin
         run(LIWL_OP_IMM_HI, 1'b0, 6'(i), 6'h0, 6'h0, 17'(rnd()));
         run(LIWL_OP_IMM_LO, 1'b0, 6'(i), 6'h0, 6'h0, 17'(rnd()));
      end
      run(LIWL_OP_IMM_ZX, 1'b0, 6'h01, 6'h0, 6'h0, 17'h0FFFF);
      run(LIWL_OP_SHORT_SIGNED_CONSTANT_SX, 1'b0, 6'h02, 6'h0, 6'h0, 17'h00040);
      run(LIWL_OP_SHORT_SIGNED_CONSTANT_SX, 1'b0, 6'h09, 6'h0, 6'h0, 17'h0003F);
      run(LIWL_OP_LONG_SIGNED_CONSTANT_SX, 1'b0, 6'h03, 6'h0, 6'h0, 17'h08000);
      run(LIWL_OP_LONG_SIGNED_CONSTANT_SX, 1'b0, 6'h14, 6'h0, 6'h0, 17'h07FFF);
      run(LIWL_OP_IMM_LO, 1'b0, 6'h03, 6'h0, 6'h0, 17'h01234);
      run(LIWL_OP_ACC0_CLR, 1'b1, 6'h0, 6'h0, 6'h0, 17'h0);
      run(LIWL_OP_ACC1_CLR, 1'b0, 6'h0, 6'h0, 6'h0, 17'h0);
      run(LIWL_OP_ACC_BOTH_CLR, 1'b1, 6'h0, 6'h0, 6'h0, 17'h0);
      run(LIWL_OP_IMM_ZX, 1'b1, 6'h05, 6'h0, 6'h0, 17'h00055);
      chk_all("immediates");
      run(LIWL_OP_IMM_ZX, 1'b0, 6'h08, 6'h0, 6'h0, 17'h01000);
      run(LIWL_OP_IMM_ZX, 1'b0, 6'h0A, 6'h0, 6'h0, 17'h01002);
      run(LIWL_OP_IMM_ZX, 1'b0, 6'h0B, 6'h0, 6'h0, 17'h03000);
      run(LIWL_OP_IMM_ZX, 1'b0, IDX_FRAME, 6'h0, 6'h0, 17'h08000);
      run(LIWL_OP_IMM_ZX, 1'b0, IDX_INDEX0, 6'h0, 6'h0, 17'h04000);
      run(LIWL_OP_IMM_ZX, 1'b0, IDX_MOD0, 6'h0, 6'h0, 17'h00008);
      run(LIWL_OP_LD_IND, 1'b0, 6'h00, 6'h08, 6'h0, 17'h0);
      run(LIWL_OP_LD_INC, 1'b1, 6'h09, 6'h08, 6'h0, 17'h0);
      run(LIWL_OP_LD_DEC, 1'b0, 6'h01, 6'h0B, 6'h0, 17'h0);
      run(LIWL_OP_LD_SHORT, 1'b1, 6'h02, 6'h08, 6'h0, 17'h0003C);
      run(LIWL_OP_LD_LONG_ADD, 1'b0, 6'h03, 6'h08, 6'h0, 17'h1FFFC);
      run(LIWL_OP_LD_LONG_SUB, 1'b0, 6'h04, 6'h0B, 6'h0, 17'h1FFFC);
      run(LIWL_OP_LD_FRAME, 1'b0, 6'h05, IDX_FRAME, 6'h0, 17'h00004);
      run(LIWL_OP_LD_FRAME, 1'b0, 6'h06, IDX_FRAME, 6'h0, 17'h0007C);
      run(LIWL_OP_LD_FRAME, 1'b0, 6'h05, IDX_FRAME, 6'h0, 17'h00080);
      run(LIWL_OP_LD_IDX_POST, 1'b0, 6'h07, IDX_INDEX0, IDX_MOD0, 17'h0);
      run(LIWL_OP_LD_INC, 1'b0, 6'h06, IDX_INDEX0, 6'h0, 17'h0);
      run(LIWL_OP_LD_IDX_POST, 1'b0, 6'h00, 6'h08, 6'h08, 17'h0);
      run(LIWL_OP_LD_IDX_POST, 1'b0, 6'h01, 6'h08, 6'h0B, 17'h0);
      run(LIWL_OP_LD_IND, 1'b0, 6'h02, 6'h0A, 6'h0, 17'h0);
      run(LIWL_OP_LD_INC, 1'b0, 6'h08, 6'h08, 6'h0, 17'h0);
      run(LIWL_OP_LD_DEC, 1'b0, 6'h0B, 6'h0B, 6'h0, 17'h0);
      run(LIWL_OP_LD_LONG_SUB, 1'b1, 6'h03, 6'h08, 6'h0, 17'h00004);
      run(LIWL_OP_LD_SHORT, 1'b0, 6'h04, 6'h0A, 6'h0, 17'h00004);
      run(LIWL_OP_LD_IND, 1'b0, IDX_INDEX0, 6'h08, 6'h0, 17'h0);
      run(LIWL_OP_SHORT_SIGNED_CONSTANT_SX, 1'b0, IDX_INDEX0, 6'h0, 6'h0, 17'h00011);
      chk_all("loads");
      check("notes left", 40'(notes.size()), 40'h0);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
